//--- bench/sits_phy_model.sv
// far-side model: training engines, pattern reads, read strobe burst
// assumes user_logic_clock handshakes; strobe pin pulled low outside bursts
`timescale 1ns/1ps
module sits_phy_model
   import sits_pkg::*;
(
   input  wire logic [4:0] starts,
   input  wire logic       user_logic_clock,
   input  wire logic       cmd_valid,
   input  sits_cmd_t       cmd_code,
   input  wire logic [6:0] dqs_delay,
   input  wire logic [6:0] lo,
   input  wire logic [6:0] hi,
   output logic      [4:0] dones = 0,
   output logic            rd_vld = 0,
   output logic            rd_ok = 0,
   output logic            strobe = 0
);
   int k = 99;
   always @(posedge user_logic_clock)
   begin
      // done comes late at random, then stays until the start drops
      dones <= starts & (dones | {5{$urandom_range(3) == 0}});
      k <= (cmd_valid && cmd_code == SITS_CMD_READ) ? 0 : k + 1;
      rd_vld <= k == 3;
      rd_ok <= k == 3 && dqs_delay >= lo && dqs_delay <= hi;
      strobe <= k > 36 && k < 60 && k[2];
   end
endmodule

//--- bench/sits_seq_chk.sv
// port checker for sits_seq, bound to every instance
// assumes one clock domain
`timescale 1ns/1ps
module sits_seq_chk
(
   input wire logic       user_logic_clock,
   input wire logic       resetn,
   input wire logic       reinit_request,
   input wire logic       clk_train_start,
   input wire logic       ca_train_start,
   input wire logic       wl_start,
   input wire logic       dq_align_start,
   input wire logic       wcal_start,
   input wire logic       mem_reset_n,
   input wire logic       mem_cke,
   input wire logic       gate_open,
   input wire logic [3:0] fifo_wr_ptr,
   input wire logic       init_done_flag
);
   default clocking @(posedge user_logic_clock); endclocking
   default disable iff (!resetn);
   AST_DONE_RST: assert property ($rose(resetn) |-> !init_done_flag)
      else $error("done flag high after reset");
   AST_REINIT: assert property ($rose(reinit_request) |->
      ##[1:2] (!init_done_flag && clk_train_start)) else $error("no restart");
   AST_CA_ORDER: assert property ($rose(ca_train_start) |->
      $past(clk_train_start)) else $error("ca training out of order");
   AST_RST_LEN: assert property ($rose(mem_reset_n) |->
      $past(mem_reset_n, 8) == 1'b0) else $error("reset low too short");
   AST_CKE_LATE: assert property ($rose(mem_reset_n) |-> !mem_cke[*8])
      else $error("cke early");
   AST_STEP_ONE: assert property ($onehot0({clk_train_start,
      ca_train_start, wl_start, dq_align_start, wcal_start}))
      else $error("two steps at once");
   AST_DONE_END: assert property ($rose(init_done_flag) |->
      $past(wcal_start) || $past(wcal_start, 2)) else $error("early done");
   AST_FIFO_GATE: assert property ($changed(fifo_wr_ptr) &&
      fifo_wr_ptr != 4'h0 |-> gate_open || $past(gate_open))
      else $error("fifo moved outside gate");
   cover property ($rose(init_done_flag));
   cover property ($rose(reinit_request));
   cover property ($rose(gate_open));
endmodule
bind sits_seq sits_seq_chk sits_seq_chk_inst (.user_logic_clock, .resetn,
   .reinit_request, .clk_train_start, .ca_train_start, .wl_start,
   .dq_align_start, .wcal_start, .mem_reset_n, .mem_cke, .gate_open,
   .fifo_wr_ptr, .init_done_flag);

//--- bench/test_sits_seq.sv
// bench for sits_seq: every memory type, reinit mid-run and after done
// assumes sits_phy_model on the far side
`timescale 1ns/1ps
module test_sits_seq
   import sits_pkg::*;
;
   logic       user_logic_clock = 0, resetn = 0, reinit = 0, rm = 0, lr = 0;
   logic [7:0] gd;
   logic       vld, ok, stb, cv, done;
   sits_mem_t  mem = SITS_DDR3;
   sits_cmd_t  cc;
   logic [1:0] rl = 0;
   logic [6:0] lo = 7'h30, hi = 7'h50, dqs;
   logic [4:0] st, dn, mr, q[$];
   int         num_errors = 0, comparisons = 0, nzq = 0, ncw = 0;
   sits_seq #(.RST_CYC(20), .CKE_CYC(30), .LPCKE_CYC(20), .INIT5_CYC(5))
   sits_seq_inst (.user_logic_clock, .resetn, .pll_lock(resetn),
      .reinit_request(reinit), .mem_type(mem), .rank_last(rl),
      .registered_module(rm), .load_reduced_module(lr),
      .clk_train_done(dn[0]), .ca_train_done(dn[1]), .phy_ready(resetn),
      .wl_done(dn[2]), .dq_align_done(dn[3]), .wcal_done(dn[4]),
      .rd_result_vld(vld), .rd_result_ok(ok), .rd_strobe_pin(stb),
      .clk_train_start(st[0]), .ca_train_start(st[1]), .wl_start(st[2]),
      .dq_align_start(st[3]), .wcal_start(st[4]), .mem_reset_n(),
      .mem_cke(), .cmd_valid(cv), .cmd_code(cc), .cmd_mr(mr),
      .cmd_rank(), .gate_delay(gd), .dqs_delay(dqs), .gate_open(),
      .fifo_wr_ptr(), .init_done_flag(done));
   sits_phy_model sits_phy_model_inst (.starts(st), .user_logic_clock,
      .cmd_valid(cv), .cmd_code(cc), .dqs_delay(dqs), .lo, .hi,
      .dones(dn), .rd_vld(vld), .rd_ok(ok), .strobe(stb));
   initial
      forever #12.5 user_logic_clock = ~user_logic_clock;
   always @(posedge user_logic_clock)
      if (cv && cc == SITS_CMD_MRS) q.push_back(mr);
      else if (cv && cc inside {SITS_CMD_ZQCL, SITS_CMD_ZQINIT}) nzq++;
      else if (cv && cc inside {SITS_CMD_RCW, SITS_CMD_BCW}) ncw++;
   // mode register order per type, low byte first, ff past the end
   function automatic logic [7:0] exp_mr(sits_mem_t m, int i);
      logic [55:0] v;
      v = m == SITS_DDR3 ? 56'hffffff00010302 : m == SITS_DDR4 ?
          56'h00010204050603 : 56'hffff1110030201;
      return v[8*i +: 8];
   endfunction
   task automatic check(logic [7:0] seen, logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("Error %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic pulse;
      @(posedge user_logic_clock);
      #2 reinit = 1;
      repeat (3) @(posedge user_logic_clock);
      #2 reinit = 0;
      // commands of the discarded run have all been seen by now
      q = {};
      nzq = 0;
      ncw = 0;
      check(8'(done), 8'h0);
   endtask
   initial
   begin
      void'($urandom(76389));
      repeat (10) @(posedge user_logic_clock);
      #2 resetn = 1;
      for (int t = 0; t < 5; t++)
      begin
         if (t > 0)
         begin
            mem = sits_mem_t'(t % 3);
            rl = 2'($urandom_range(3));
            // ddr4 twice: a buffered module first, a plain one later
            rm = 1'(t == 1 && $urandom_range(1) == 1);
            lr = 1'(t == 1) & ~rm;
            lo = 7'h20 + 7'($urandom_range(31));
            hi = 7'h41 + 7'($urandom_range(31));
            pulse;
         end
         // a restart in mid-sequence must discard the partial run
         if (t == 3)
         begin
            repeat (150) @(posedge user_logic_clock);
            pulse;
         end
         for (int n = 0; done !== 1'b1; n++)
         begin
            @(posedge user_logic_clock);
            #2;
            if (n > 60000)
            begin
               num_errors++;
               end_of_test;
            end
         end
         for (int i = 0; i < 7; i++)
            check(i < q.size() ? 8'(q[i]) : 8'hff, exp_mr(mem, i));
         check(8'(nzq), 8'(rl) + 8'h1);
         check(8'(dqs), (8'(lo) + 8'(hi)) >> 1);
         check(8'(ncw), {6'h0, mem == SITS_DDR4 && (rm | lr), 1'b0});
         // model strobe first sampled high at 0x28: +1, then back by 4
         check(gd, 8'h25);
      end
      end_of_test;
   end
endmodule

//--- hw/sits_gate_ctl.sv
// read strobe gate: opens a programmable delay after a read launch,
// closes on an internal post-amble timer, qualifies strobe edges
// assumes the strobe pin is asynchronous to user_logic_clock
`timescale 1ns/1ps
module sits_gate_ctl
   import sits_pkg::*;
(
   input  logic       user_logic_clock,
   input  logic       resetn,
   input  logic       rd_launch,
   input  logic [7:0] gate_pos,
   input  logic       rd_strobe_pin,
   output logic       gate_open,
   output logic       gate_smp,
   output logic       gate_smp_vld,
   output logic [3:0] fifo_wr_ptr
);
`include "sits_map.svh"

   logic       strb_s1_ff;
   logic       strb_s2_ff;
   logic       strb_s3_ff;
   logic       run_ff;
   logic       open_ff;
   logic [7:0] gcnt_ff;
   logic       smp_ff;
   logic       smp_vld_ff;
   logic [3:0] wptr_ff;

   wire [7:0] fall_pos = 8'(gate_pos + `SITS_GATE_HOLD);
   wire at_rise = run_ff && !open_ff && (gcnt_ff == gate_pos);
   wire at_fall = open_ff && (gcnt_ff == fall_pos);
   wire strb_rise = strb_s2_ff & ~strb_s3_ff;
   // only edges inside the gate move the fifo pointer
   wire wr_step = strb_rise & open_ff;

   always_ff @(posedge user_logic_clock)
   begin
      strb_s1_ff <= rd_strobe_pin;
      strb_s2_ff <= strb_s1_ff;
      strb_s3_ff <= strb_s2_ff;
   end

   always_ff @(posedge user_logic_clock)
   begin
      if (!resetn)
      begin
         run_ff     <= 1'b0;
         open_ff    <= 1'b0;
         gcnt_ff    <= 8'h00;
         smp_ff     <= 1'b0;
         smp_vld_ff <= 1'b0;
         wptr_ff    <= 4'h0;
      end
      else
      begin
         gcnt_ff    <= rd_launch ? 8'h00 : 8'(gcnt_ff + 8'h01);
         run_ff     <= rd_launch | (run_ff & ~at_fall);
         // a new launch closes a gate left open, or its rise is lost
         open_ff    <= at_rise | (open_ff & ~at_fall & ~rd_launch);
         smp_vld_ff <= at_rise;
         if (at_rise)
            smp_ff  <= strb_s2_ff;
         if (wr_step)
            wptr_ff <= 4'(wptr_ff + 4'h1);
      end
   end

   assign gate_open    = open_ff;
   assign gate_smp     = smp_ff;
   assign gate_smp_vld = smp_vld_ff;
   assign fifo_wr_ptr  = wptr_ff;

endmodule

//--- hw/sits_map.svh
// constant map for the sdram init and training sequencer
// assumes a 40 MHz user clock; included by bare name
`ifndef SITS_MAP_SVH
`define SITS_MAP_SVH

// -------------------------------------------------------------------
// clock and wait times
// -------------------------------------------------------------------
`define SITS_CLK_MHZ        40
`define SITS_T_RST_US       200
`define SITS_T_CKE_US       600
`define SITS_T_LPCKE_US     200
`define SITS_T_XPR_NS       400
`define SITS_T_INIT5_NS     10000
`define SITS_T_ZQINIT_NS    1000
`define SITS_LP_CKE_LOW_CYC 100
`define SITS_GEAR_CYC       128
`define SITS_ZQ_CYC         512
// least times round up to whole cycles
`define SITS_US2CYC(t) ((t) * `SITS_CLK_MHZ)
`define SITS_NS2CYC(t) ((((t) * `SITS_CLK_MHZ) + 999) / 1000)

// -------------------------------------------------------------------
// training positions
// -------------------------------------------------------------------
`define SITS_GATE_MID  8'h20
`define SITS_GATE_QTR  8'h01
`define SITS_GATE_MCLK 8'h04
`define SITS_GATE_HOLD 8'h06
`define SITS_DQS_MID   7'h40
`define SITS_DQS_MAX   7'h7f

// -------------------------------------------------------------------
// mode register sequences: last index per memory type
// -------------------------------------------------------------------
`define SITS_D3_MR_LAST 3'h3
`define SITS_D4_MR_LAST 3'h6
`define SITS_LP_MR_LAST 3'h4

`endif

//--- hw/sits_pkg.sv
// types shared by the sdram init and training sequencer
// assumes nothing beyond a standard elaborator
package sits_pkg;

   typedef enum logic [1:0] {SITS_DDR3, SITS_DDR4, SITS_LPDDR3} sits_mem_t;

   typedef enum logic [2:0] {
      SITS_CMD_NONE, SITS_CMD_MRS, SITS_CMD_ZQCL, SITS_CMD_RCW,
      SITS_CMD_BCW, SITS_CMD_MRW_RST, SITS_CMD_ZQINIT, SITS_CMD_READ
   } sits_cmd_t;

   typedef enum logic [4:0] {
      ST_IDLE, ST_CLK_TRN, ST_CA_TRN, ST_PHY_WAIT, ST_RST_LOW,
      ST_CKE_LOW, ST_TXPR, ST_RCW, ST_MRS, ST_GEAR, ST_ZQ,
      ST_LP_CKE_LOW, ST_LP_CKE_HIGH, ST_LP_INIT5, ST_LP_ZQ, ST_WLVL,
      ST_GATE_FIND, ST_GATE_BACK, ST_DQ_ALIGN, ST_CTR_LEFT,
      ST_CTR_RIGHT, ST_WCAL, ST_DONE
   } sits_state_t;

endpackage

//--- hw/sits_seq.sv
// sdram init and training sequencer top
// assumes phy training engines answer with same-clock done levels,
// and user logic drives reinit_request on user_logic_clock
//
// Summary of operation
// - controller issues reads for gate training
// - gate starts mid-burst, finds 0-to-1
// - on transition advance gate 90 degrees
// - step back one clock until zero
// - falling gate edge placed by timer
// - gate qualifies strobe before fifo pointer
// - align dq bits before placing strobe
// - sweep strobe both ways, take midpoint
// - run io calibration after power-up
// - done flag only after whole sequence
// - clock, then ca training, then phy
// - ddr3/4 reset 200us, cke 600us, txpr
// - ddr3 mode registers 2,3,1,0
// - ddr3 512 cycles with zqcl per rank
// - ddr4 control words for buffered modules
// - ddr4 mode registers 3,6,5,4,2,1,0
// - ddr4 128 geardown then 512 zqcl
// - leveling, gate, dq, dqs, write cal
// - lpddr3 cke low 100, high 200us
// - lpddr3 mrw reset, zq init per rank
// - lpddr3 mode registers 1,2,3,16,17
// - reinit rising edge restarts full sequence
// - done low in reset and on reinit
`timescale 1ns/1ps
`include "sits_map.svh"
module sits_seq
   import sits_pkg::*;
#(
   parameter int RST_CYC   = `SITS_US2CYC(`SITS_T_RST_US),
   parameter int CKE_CYC   = `SITS_US2CYC(`SITS_T_CKE_US),
   parameter int LPCKE_CYC = `SITS_US2CYC(`SITS_T_LPCKE_US),
   parameter int INIT5_CYC = `SITS_NS2CYC(`SITS_T_INIT5_NS)
)
(
   input  logic       user_logic_clock,
   input  logic       resetn,
   input  logic       pll_lock,
   input  logic       reinit_request,
   input  sits_mem_t  mem_type,
   input  logic [1:0] rank_last,
   input  logic       registered_module,
   input  logic       load_reduced_module,
   input  logic       clk_train_done,
   input  logic       ca_train_done,
   input  logic       phy_ready,
   input  logic       wl_done,
   input  logic       dq_align_done,
   input  logic       wcal_done,
   input  logic       rd_result_vld,
   input  logic       rd_result_ok,
   input  logic       rd_strobe_pin,
   output logic       clk_train_start,
   output logic       ca_train_start,
   output logic       wl_start,
   output logic       dq_align_start,
   output logic       wcal_start,
   output logic       mem_reset_n,
   output logic       mem_cke,
   output logic       cmd_valid,
   output sits_cmd_t  cmd_code,
   output logic [4:0] cmd_mr,
   output logic [1:0] cmd_rank,
   output logic [7:0] gate_delay,
   output logic [6:0] dqs_delay,
   output logic       gate_open,
   output logic [3:0] fifo_wr_ptr,
   output logic       init_done_flag
);

   // -------------------------------------------------------------------
   // wait counts and mode register tables
   // -------------------------------------------------------------------
   localparam int XPR_CYC    = `SITS_NS2CYC(`SITS_T_XPR_NS);
   localparam int ZQINIT_CYC = `SITS_NS2CYC(`SITS_T_ZQINIT_NS);

   localparam logic [4:0] D3_TAB [0:3] = '{5'h02, 5'h03, 5'h01, 5'h00};
   localparam logic [4:0] D4_TAB [0:7] =
      '{5'h03, 5'h06, 5'h05, 5'h04, 5'h02, 5'h01, 5'h00, 5'h00};
   localparam logic [4:0] LP_TAB [0:7] =
      '{5'h01, 5'h02, 5'h03, 5'h10, 5'h11, 5'h00, 5'h00, 5'h00};

   // -------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------
   sits_state_t st_ff;
   sits_state_t nxt_st;
   logic [15:0] cnt_ff;
   logic [15:0] nxt_cnt;
   logic [2:0]  idx_ff;
   logic [2:0]  nxt_idx;
   logic        wait_ff;
   logic        nxt_wait;
   logic        rst_n_ff;
   logic        nxt_rst_n;
   logic        cke_ff;
   logic        nxt_cke;
   logic        done_ff;
   logic        nxt_done;
   logic        prev_smp_ff;
   logic        nxt_prev_smp;
   logic [7:0]  gate_pos_ff;
   logic [7:0]  nxt_gate_pos;
   logic [6:0]  dqs_pos_ff;
   logic [6:0]  nxt_dqs_pos;
   logic [6:0]  left_ff;
   logic [6:0]  nxt_left;
   logic        cmd_vld_ff;
   logic        nxt_cmd_vld;
   sits_cmd_t   cmd_code_ff;
   sits_cmd_t   nxt_cmd_code;
   logic [4:0]  cmd_mr_ff;
   logic [4:0]  nxt_cmd_mr;
   logic [1:0]  cmd_rank_ff;
   logic [1:0]  nxt_cmd_rank;
   logic        pll_s1_ff;
   logic        pll_s2_ff;
   logic        reinit_prev_ff;
   logic        gate_smp;
   logic        gate_smp_vld;

   // -------------------------------------------------------------------
   // decode
   // -------------------------------------------------------------------
   wire is_d3 = (mem_type == SITS_DDR3);
   wire is_d4 = (mem_type == SITS_DDR4);
   wire is_lp = (mem_type == SITS_LPDDR3);
   wire cnt_zero = (cnt_ff == 16'h0000);
   wire reinit_rise = reinit_request & ~reinit_prev_ff;
   wire buffered = registered_module | load_reduced_module;
   wire [4:0] mr_sel = is_d3 ? D3_TAB[idx_ff[1:0]] :
                       is_d4 ? D4_TAB[idx_ff] : LP_TAB[idx_ff];
   wire [2:0] mr_last = is_d3 ? `SITS_D3_MR_LAST :
                        is_d4 ? `SITS_D4_MR_LAST : `SITS_LP_MR_LAST;
   wire [2:0] rank_last3 = {1'b0, rank_last};
   wire [7:0] dqs_sum = {1'b0, left_ff} + {1'b0, dqs_pos_ff};
   wire [7:0] dqs_sum_m1 = 8'(dqs_sum - 8'h01);
   wire gate_low = (gate_pos_ff < `SITS_GATE_MCLK);

   // -------------------------------------------------------------------
   // sequencer
   // -------------------------------------------------------------------
   always_comb
   begin
      nxt_st       = st_ff;
      nxt_cnt      = cnt_zero ? 16'h0000 : 16'(cnt_ff - 16'h0001);
      nxt_idx      = idx_ff;
      nxt_wait     = wait_ff;
      nxt_rst_n    = rst_n_ff;
      nxt_cke      = cke_ff;
      nxt_done     = done_ff;
      nxt_prev_smp = prev_smp_ff;
      nxt_gate_pos = gate_pos_ff;
      nxt_dqs_pos  = dqs_pos_ff;
      nxt_left     = left_ff;
      nxt_cmd_vld  = 1'b0;
      nxt_cmd_code = cmd_code_ff;
      nxt_cmd_mr   = cmd_mr_ff;
      nxt_cmd_rank = cmd_rank_ff;
      unique case (st_ff)
         ST_IDLE:
            if (pll_s2_ff)
               nxt_st = ST_CLK_TRN;
         ST_CLK_TRN:
            if (clk_train_done)
               nxt_st = ST_CA_TRN;
         ST_CA_TRN:
            if (ca_train_done)
               nxt_st = ST_PHY_WAIT;
         ST_PHY_WAIT:
            if (phy_ready)
            begin
               nxt_cke = 1'b0;
               if (is_lp)
               begin
                  nxt_st  = ST_LP_CKE_LOW;
                  nxt_cnt = 16'(`SITS_LP_CKE_LOW_CYC - 1);
               end
               else
               begin
                  nxt_st    = ST_RST_LOW;
                  nxt_rst_n = 1'b0;
                  nxt_cnt   = 16'(RST_CYC - 1);
               end
            end
         ST_RST_LOW:
            if (cnt_zero)
            begin
               nxt_rst_n = 1'b1;
               nxt_st    = ST_CKE_LOW;
               nxt_cnt   = 16'(CKE_CYC - 1);
            end
         ST_CKE_LOW:
            if (cnt_zero)
            begin
               nxt_cke = 1'b1;
               nxt_st  = ST_TXPR;
               nxt_cnt = 16'(XPR_CYC - 1);
            end
         ST_TXPR:
            if (cnt_zero)
            begin
               nxt_idx = 3'h0;
               nxt_st  = (is_d4 && buffered) ? ST_RCW : ST_MRS;
            end
         ST_RCW:
         begin
            nxt_cmd_vld  = 1'b1;
            nxt_cmd_code = (idx_ff == 3'h0) ? SITS_CMD_RCW : SITS_CMD_BCW;
            nxt_idx      = 3'(idx_ff + 3'h1);
            if (idx_ff != 3'h0)
            begin
               nxt_idx = 3'h0;
               nxt_st  = ST_MRS;
            end
         end
         ST_MRS:
         begin
            nxt_cmd_vld  = 1'b1;
            nxt_cmd_code = SITS_CMD_MRS;
            nxt_cmd_mr   = mr_sel;
            nxt_idx      = 3'(idx_ff + 3'h1);
            if (idx_ff == mr_last)
            begin
               nxt_idx = 3'h0;
               if (is_lp)
                  nxt_st = ST_WLVL;
               else if (is_d4)
               begin
                  nxt_st  = ST_GEAR;
                  nxt_cnt = 16'(`SITS_GEAR_CYC - 1);
               end
               else
               begin
                  nxt_st  = ST_ZQ;
                  nxt_cnt = 16'(`SITS_ZQ_CYC - 1);
               end
            end
         end
         ST_GEAR:
            if (cnt_zero)
            begin
               nxt_st  = ST_ZQ;
               nxt_cnt = 16'(`SITS_ZQ_CYC - 1);
            end
         ST_ZQ:
         begin
            // one zqcl per rank at the head of the wait
            if (idx_ff <= rank_last3)
            begin
               nxt_cmd_vld  = 1'b1;
               nxt_cmd_code = SITS_CMD_ZQCL;
               nxt_cmd_rank = idx_ff[1:0];
               nxt_idx      = 3'(idx_ff + 3'h1);
            end
            if (cnt_zero)
               nxt_st = ST_WLVL;
         end
         ST_LP_CKE_LOW:
            if (cnt_zero)
            begin
               nxt_cke = 1'b1;
               nxt_st  = ST_LP_CKE_HIGH;
               nxt_cnt = 16'(LPCKE_CYC - 1);
            end
         ST_LP_CKE_HIGH:
            if (cnt_zero)
            begin
               nxt_cmd_vld  = 1'b1;
               nxt_cmd_code = SITS_CMD_MRW_RST;
               nxt_st       = ST_LP_INIT5;
               nxt_cnt      = 16'(INIT5_CYC - 1);
            end
         ST_LP_INIT5:
            if (cnt_zero)
            begin
               nxt_st   = ST_LP_ZQ;
               nxt_idx  = 3'h0;
               nxt_wait = 1'b0;
            end
         ST_LP_ZQ:
            if (!wait_ff)
            begin
               nxt_cmd_vld  = 1'b1;
               nxt_cmd_code = SITS_CMD_ZQINIT;
               nxt_cmd_rank = idx_ff[1:0];
               nxt_cnt      = 16'(ZQINIT_CYC - 1);
               nxt_wait     = 1'b1;
            end
            else if (cnt_zero)
            begin
               nxt_wait = 1'b0;
               nxt_idx  = 3'(idx_ff + 3'h1);
               if (idx_ff == rank_last3)
               begin
                  nxt_idx = 3'h0;
                  nxt_st  = ST_MRS;
               end
            end
         ST_WLVL:
            if (wl_done)
            begin
               nxt_st       = ST_GATE_FIND;
               nxt_gate_pos = `SITS_GATE_MID;
               nxt_prev_smp = 1'b0;
               nxt_wait     = 1'b0;
            end
         ST_GATE_FIND:
            if (!wait_ff)
            begin
               nxt_cmd_vld  = 1'b1;
               nxt_cmd_code = SITS_CMD_READ;
               nxt_wait     = 1'b1;
            end
            else if (gate_smp_vld)
            begin
               nxt_wait     = 1'b0;
               nxt_prev_smp = gate_smp;
               if (!prev_smp_ff && gate_smp)
               begin
                  // move into the middle of the high pulse
                  nxt_gate_pos = 8'(gate_pos_ff + `SITS_GATE_QTR);
                  nxt_st       = ST_GATE_BACK;
               end
               else
                  nxt_gate_pos = 8'(gate_pos_ff + `SITS_GATE_QTR);
            end
         ST_GATE_BACK:
            if (!wait_ff)
            begin
               nxt_cmd_vld  = 1'b1;
               nxt_cmd_code = SITS_CMD_READ;
               nxt_wait     = 1'b1;
            end
            else if (gate_smp_vld)
            begin
               nxt_wait = 1'b0;
               // a zero marks the preamble; floor stops a runaway walk
               if (!gate_smp || gate_low)
                  nxt_st = ST_DQ_ALIGN;
               else
                  nxt_gate_pos = 8'(gate_pos_ff - `SITS_GATE_MCLK);
            end
         ST_DQ_ALIGN:
            if (dq_align_done)
            begin
               nxt_st      = ST_CTR_LEFT;
               nxt_dqs_pos = `SITS_DQS_MID;
               nxt_wait    = 1'b0;
            end
         ST_CTR_LEFT:
            if (!wait_ff)
            begin
               nxt_cmd_vld  = 1'b1;
               nxt_cmd_code = SITS_CMD_READ;
               nxt_wait     = 1'b1;
            end
            else if (rd_result_vld)
            begin
               nxt_wait = 1'b0;
               if (rd_result_ok && dqs_pos_ff != 7'h00)
                  nxt_dqs_pos = 7'(dqs_pos_ff - 7'h01);
               else
               begin
                  nxt_left    = rd_result_ok ? dqs_pos_ff :
                                7'(dqs_pos_ff + 7'h01);
                  nxt_dqs_pos = `SITS_DQS_MID;
                  nxt_st      = ST_CTR_RIGHT;
               end
            end
         ST_CTR_RIGHT:
            if (!wait_ff)
            begin
               nxt_cmd_vld  = 1'b1;
               nxt_cmd_code = SITS_CMD_READ;
               nxt_wait     = 1'b1;
            end
            else if (rd_result_vld)
            begin
               nxt_wait = 1'b0;
               if (rd_result_ok && dqs_pos_ff != `SITS_DQS_MAX)
                  nxt_dqs_pos = 7'(dqs_pos_ff + 7'h01);
               else
               begin
                  // midpoint of the two passing edges
                  nxt_dqs_pos = rd_result_ok ? dqs_sum[7:1] :
                                dqs_sum_m1[7:1];
                  nxt_st      = ST_WCAL;
               end
            end
         ST_WCAL:
            if (wcal_done)
            begin
               nxt_st   = ST_DONE;
               nxt_done = 1'b1;
            end
         ST_DONE:
            nxt_st = ST_DONE;
      endcase
      if (reinit_rise)
      begin
         nxt_st      = ST_CLK_TRN;
         nxt_done    = 1'b0;
         nxt_wait    = 1'b0;
         nxt_idx     = 3'h0;
         nxt_cmd_vld = 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // registers
   // -------------------------------------------------------------------
   always_ff @(posedge user_logic_clock)
   begin
      pll_s1_ff <= pll_lock;
      pll_s2_ff <= pll_s1_ff;
   end

   always_ff @(posedge user_logic_clock)
   begin
      if (!resetn)
      begin
         st_ff          <= ST_IDLE;
         cnt_ff         <= 16'h0000;
         idx_ff         <= 3'h0;
         wait_ff        <= 1'b0;
         rst_n_ff       <= 1'b0;
         cke_ff         <= 1'b0;
         done_ff        <= 1'b0;
         prev_smp_ff    <= 1'b0;
         gate_pos_ff    <= `SITS_GATE_MID;
         dqs_pos_ff     <= `SITS_DQS_MID;
         left_ff        <= 7'h00;
         cmd_vld_ff     <= 1'b0;
         cmd_code_ff    <= SITS_CMD_NONE;
         cmd_mr_ff      <= 5'h00;
         cmd_rank_ff    <= 2'h0;
         reinit_prev_ff <= 1'b0;
      end
      else
      begin
         st_ff          <= nxt_st;
         cnt_ff         <= nxt_cnt;
         idx_ff         <= nxt_idx;
         wait_ff        <= nxt_wait;
         rst_n_ff       <= nxt_rst_n;
         cke_ff         <= nxt_cke;
         done_ff        <= nxt_done;
         prev_smp_ff    <= nxt_prev_smp;
         gate_pos_ff    <= nxt_gate_pos;
         dqs_pos_ff     <= nxt_dqs_pos;
         left_ff        <= nxt_left;
         cmd_vld_ff     <= nxt_cmd_vld;
         cmd_code_ff    <= nxt_cmd_code;
         cmd_mr_ff      <= nxt_cmd_mr;
         cmd_rank_ff    <= nxt_cmd_rank;
         reinit_prev_ff <= reinit_request;
      end
   end

   // -------------------------------------------------------------------
   // gate and strobe qualification
   // -------------------------------------------------------------------
   wire rd_launch = cmd_vld_ff && (cmd_code_ff == SITS_CMD_READ);

   sits_gate_ctl u_gate (
      .user_logic_clock       (user_logic_clock),
      .resetn        (resetn),
      .rd_launch     (rd_launch),
      .gate_pos      (gate_pos_ff),
      .rd_strobe_pin (rd_strobe_pin),
      .gate_open     (gate_open),
      .gate_smp      (gate_smp),
      .gate_smp_vld  (gate_smp_vld),
      .fifo_wr_ptr   (fifo_wr_ptr)
   );

   // -------------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------------
   assign clk_train_start = (st_ff == ST_CLK_TRN);
   assign ca_train_start  = (st_ff == ST_CA_TRN);
   assign wl_start        = (st_ff == ST_WLVL);
   assign dq_align_start  = (st_ff == ST_DQ_ALIGN);
   assign wcal_start      = (st_ff == ST_WCAL);
   assign mem_reset_n     = rst_n_ff;
   assign mem_cke         = cke_ff;
   assign cmd_valid       = cmd_vld_ff;
   assign cmd_code        = cmd_code_ff;
   assign cmd_mr          = cmd_mr_ff;
   assign cmd_rank        = cmd_rank_ff;
   assign gate_delay      = gate_pos_ff;
   assign dqs_delay       = dqs_pos_ff;
   assign init_done_flag  = done_ff;

endmodule
